// ==== bam_mode_regs.sv ====
// Low-capacity, low-time and mode word registers with alarm broadcast control
`timescale 1ns/1ps

// What this block does
// - Alarm when remaining charge below capacity threshold
// - Zero capacity threshold disables that alarm
// - Capacity threshold loaded from config, host-changed only
// - Capacity threshold unsigned 16-bit, units by mode
// - Alarm when runtime estimate below time threshold
// - Zero time threshold disables that alarm
// - Time threshold loaded from config, host-changed only
// - Time threshold unsigned 16-bit minutes
// - All three registers word read and write
// - Mode bits 13 to 15 writable, all other bits read-only
// - Relearn flag set on reset, 20 unlearned cycles
// - Relearn flag cleared after learning completes
// - Mode bit 13 stops alarm broadcasts
// - Mode bit 14 stops charging broadcasts
// - Mode bit 15 selects power/energy reporting units
// - Mode write restarts 60 s alarm re-enable timer
// - Alarm broadcasts spaced at least 10 s
module bam_mode_regs
    import bam_pkg::*;
#(
    parameter int CYCLES_SEC = CYCLES_PER_SEC,
    parameter int REARM_S = MODE_REARM_S,
    parameter int SPACING_S = ALARM_SPACING_S,
    parameter int RELEARN_COUNT = RELEARN_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Word command port
    input wire logic [7:0] cmd_code,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic rd_stb,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic cmd_unmapped,
    // Defaults from the config_store
    input wire logic cfg_load,
    input wire logic [15:0] cfg_low_cap_default,
    input wire logic [15:0] cfg_low_time_default,
    // Gauge measurements and events
    input wire logic [15:0] remaining_charge_report,
    input wire logic [15:0] avg_runtime_estimate,
    input wire logic charge_cycle_done,
    input wire logic full_charge_capacity_update,
    input wire logic learn_cycle_done,
    input wire logic sleep_entry,
    // Alarm message engine
    output logic alarm_message_req,
    output logic [1:0] alarm_message_status,
    input wire logic alarm_message_done,
    // Mode outputs
    output logic capacity_units_power,
    output logic charge_bcast_en,
    output logic alarm_bcast_en,
    output logic relearn_request
);

    // ==========================================================
    // Declarations
    localparam int RCW = $clog2(RELEARN_COUNT + 1);
    localparam logic [RCW-1:0] RELEARN_LAST = RCW'(RELEARN_COUNT);
    localparam logic [SEC_TIMER_W-1:0] REARM_LOAD = SEC_TIMER_W'(REARM_S);
    // One extra tick covers the partial first second
    localparam logic [SEC_TIMER_W-1:0] SPACING_LOAD = SEC_TIMER_W'(SPACING_S + 1);

    logic [15:0] low_capacity_threshold;
    logic [15:0] low_time_threshold;
    logic alarm_off;
    logic charger_off;
    logic capacity_mode;
    logic relearn_flag;
    logic [15:0] operating_mode_word;
    logic [RCW-1:0] unlearned_cycles;
    logic sec_tick;
    logic rearm_expired;
    logic pace_running;
    logic pace_start;
    logic cap_alarm;
    logic time_alarm;
    logic alarm_any;
    logic hit_cap;
    logic hit_time;
    logic hit_mode;
    logic mode_write;
    logic [15:0] next_rd_data;
    bam_alarm_state_e state;
    bam_alarm_state_e next_state;

    // ==========================================================
    // Command decode
    assign hit_cap = (cmd_code == CMD_LOW_CAP);
    assign hit_time = (cmd_code == CMD_LOW_TIME);
    assign hit_mode = (cmd_code == CMD_MODE);
    assign mode_write = wr_stb && hit_mode;

    // ==========================================================
    // Threshold registers
    // Full word stored unsigned; units follow the capacity mode bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_capacity_threshold <= WORD_ZERO;
        end else if (wr_stb && hit_cap) begin
            low_capacity_threshold <= wr_data;
        end else if (cfg_load) begin
            low_capacity_threshold <= cfg_low_cap_default;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_time_threshold <= WORD_ZERO;
        end else if (wr_stb && hit_time) begin
            low_time_threshold <= wr_data;
        end else if (cfg_load) begin
            low_time_threshold <= cfg_low_time_default;
        end
    end

    // ==========================================================
    // Mode word, writable high bits
    // Expiry and sleep lose to a host write in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            alarm_off <= 1'b0;
        end else if (mode_write) begin
            alarm_off <= wr_data[MODE_ALARM_OFF_BIT];
        end else if (rearm_expired || sleep_entry) begin
            alarm_off <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            charger_off <= 1'b0;
        end else if (mode_write) begin
            charger_off <= wr_data[MODE_CHARGER_OFF_BIT];
        end else if (sleep_entry) begin
            charger_off <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            capacity_mode <= 1'b0;
        end else if (mode_write) begin
            capacity_mode <= wr_data[MODE_CAPACITY_BIT];
        end else if (sleep_entry) begin
            capacity_mode <= 1'b0;
        end
    end

    // ==========================================================
    // Relearn request
    // Counts charge cycles since the last capacity update
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            unlearned_cycles <= '0;
        end else if (full_charge_capacity_update) begin
            unlearned_cycles <= '0;
        end else if (charge_cycle_done) begin
            if (unlearned_cycles == RELEARN_LAST - 1'b1) begin
                unlearned_cycles <= '0;
            end else begin
                unlearned_cycles <= unlearned_cycles + 1'b1;
            end
        end
    end

    // Set wins over the learning-done clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            relearn_flag <= 1'b1;
        end else if (!full_charge_capacity_update && charge_cycle_done
                     && unlearned_cycles == RELEARN_LAST - 1'b1) begin
            relearn_flag <= 1'b1;
        end else if (learn_cycle_done) begin
            relearn_flag <= 1'b0;
        end
    end

    // Low byte and unused high bits never store written values
    always_comb begin
        operating_mode_word = WORD_ZERO;
        operating_mode_word[0] = MODE_BIT0_READ;
        operating_mode_word[MODE_RELEARN_BIT] = relearn_flag;
        operating_mode_word[MODE_ALARM_OFF_BIT] = alarm_off;
        operating_mode_word[MODE_CHARGER_OFF_BIT] = charger_off;
        operating_mode_word[MODE_CAPACITY_BIT] = capacity_mode;
    end

    // ==========================================================
    // Read path
    always_comb begin
        next_rd_data = WORD_ZERO;
        if (hit_cap) begin
            next_rd_data = low_capacity_threshold;
        end else if (hit_time) begin
            next_rd_data = low_time_threshold;
        end else if (hit_mode) begin
            next_rd_data = operating_mode_word;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= WORD_ZERO;
        end else if (rd_stb) begin
            rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_stb;
        end
    end

    // Flags both reads and writes to an unknown command code
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmd_unmapped <= 1'b0;
        end else begin
            cmd_unmapped <= (rd_stb || wr_stb) && !(hit_cap || hit_time || hit_mode);
        end
    end

    // ==========================================================
    // Timers
    bam_tick_gen #(
        .CYCLES(CYCLES_SEC)
    ) u_tick (
        .mclk(mclk),
        .rstn(rstn),
        .tick(sec_tick)
    );

    // Whole ticks only, so the hold-off ends between 59 s and 60 s
    bam_sec_timer #(
        .W(SEC_TIMER_W)
    ) u_rearm (
        .mclk(mclk),
        .rstn(rstn),
        .start(mode_write),
        .load(REARM_LOAD),
        .tick(sec_tick),
        .running(),
        .expired(rearm_expired)
    );

    bam_sec_timer #(
        .W(SEC_TIMER_W)
    ) u_pace (
        .mclk(mclk),
        .rstn(rstn),
        .start(pace_start),
        .load(SPACING_LOAD),
        .tick(sec_tick),
        .running(pace_running),
        .expired()
    );

    // ==========================================================
    // Alarm detection
    assign cap_alarm = (low_capacity_threshold != WORD_ZERO)
                       && (remaining_charge_report < low_capacity_threshold);
    assign time_alarm = (low_time_threshold != WORD_ZERO)
                        && (avg_runtime_estimate < low_time_threshold);
    assign alarm_any = cap_alarm || time_alarm;

    // ==========================================================
    // Alarm broadcast sequencer
    // A message already on the bus is finished even if disabled meanwhile
    always_comb begin
        next_state = state;
        case (state)
            BAM_IDLE: begin
                if (alarm_any && !alarm_off && !pace_running) begin
                    next_state = BAM_SEND;
                end
            end
            BAM_SEND: begin
                if (alarm_message_done) begin
                    next_state = BAM_HOLD;
                end
            end
            BAM_HOLD: begin
                if (!pace_running) begin
                    next_state = BAM_IDLE;
                end
            end
            default: begin
                next_state = BAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= BAM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign pace_start = (state == BAM_SEND) && alarm_message_done;

    // Status is frozen for the length of one message
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            alarm_message_status <= 2'h0;
        end else if (state == BAM_IDLE && next_state == BAM_SEND) begin
            alarm_message_status[ALM_CAP_IDX] <= cap_alarm;
            alarm_message_status[ALM_TIME_IDX] <= time_alarm;
        end
    end

    assign alarm_message_req = (state == BAM_SEND);

    // ==========================================================
    // Mode outputs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            capacity_units_power <= 1'b0;
            charge_bcast_en <= 1'b1;
            alarm_bcast_en <= 1'b1;
            relearn_request <= 1'b1;
        end else begin
            capacity_units_power <= capacity_mode;
            charge_bcast_en <= !charger_off;
            alarm_bcast_en <= !alarm_off;
            relearn_request <= relearn_flag;
        end
    end

endmodule // bam_mode_regs

// ==== bam_pkg.sv ====
// Shared constants for the battery alarm and mode register bank
package bam_pkg;

    // ==========================================================
    // Command codes of the word registers
    localparam logic [7:0] CMD_LOW_CAP = 8'h01;
    localparam logic [7:0] CMD_LOW_TIME = 8'h02;
    localparam logic [7:0] CMD_MODE = 8'h03;

    // ==========================================================
    // Mode word field positions
    localparam int MODE_RELEARN_BIT = 7;
    localparam int MODE_ALARM_OFF_BIT = 13;
    localparam int MODE_CHARGER_OFF_BIT = 14;
    localparam int MODE_CAPACITY_BIT = 15;
    localparam logic [15:0] MODE_WR_MASK = 16'he000;
    localparam logic MODE_BIT0_READ = 1'b0;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ==========================================================
    // Alarm status bits carried with an alarm message
    localparam int ALM_TIME_IDX = 0;
    localparam int ALM_CAP_IDX = 1;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONE_SEC_NS = 1000000000;
    localparam int CYCLES_PER_SEC = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam int MODE_REARM_S = 60;
    localparam int ALARM_SPACING_S = 10;
    localparam int SEC_TIMER_W = 8;
    localparam int RELEARN_CYCLES = 20;

    // ==========================================================
    // Alarm broadcast sequencer, one-bit steps except HOLD back to IDLE
    typedef enum logic [1:0] {
        BAM_IDLE = 2'b00,
        BAM_SEND = 2'b01,
        BAM_HOLD = 2'b11
    } bam_alarm_state_e;

endpackage

// ==== bam_tick_gen.sv ====
// One-second enable pulse generator
`timescale 1ns/1ps
module bam_tick_gen #(
    parameter int CYCLES = 100000000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Enable pulse
    output logic tick
);
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tick <= 1'b0;
        end else begin
            tick <= (count == LAST);
        end
    end
endmodule // bam_tick_gen

// ==== bam_sec_timer.sv ====
// Down counter of one-second ticks with an expiry pulse
`timescale 1ns/1ps
module bam_sec_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic [W-1:0] load,
    input wire logic tick,
    // Status
    output logic running,
    output logic expired
);
    logic [W-1:0] count;

    // Start beats a tick in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (start) begin
            count <= load;
        end else if (tick && count != '0) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            expired <= 1'b0;
        end else begin
            expired <= !start && tick && (count == W'(1));
        end
    end

    assign running = (count != '0);
endmodule // bam_sec_timer

// ==== bam_mode_regs_props.sv ====
// Port checker for the battery alarm and mode register bank
`timescale 1ns/1ps
module bam_mode_regs_props
    import bam_pkg::*;
#(
    parameter int CYCLES_SEC = 10,
    parameter int REARM_S = 60,
    parameter int SPACING_S = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Command port
    input wire logic [7:0] cmd_code,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic rd_stb,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_unmapped,
    // Alarm and mode
    input wire logic alarm_message_req,
    input wire logic [1:0] alarm_message_status,
    input wire logic alarm_message_done,
    input wire logic alarm_bcast_en,
    input wire logic relearn_request,
    input wire logic learn_cycle_done,
    input wire logic charge_cycle_done
);
    // ==========
    // Helper counters
    // Gap allows one cycle of tick phase slack
    localparam int GAP = SPACING_S * CYCLES_SEC - 1;
    localparam int REARM = REARM_S * CYCLES_SEC + 4;
    logic [31:0] gap_cnt;
    logic [31:0] mode_age;
    logic known;
    assign known = cmd_code inside {CMD_LOW_CAP, CMD_LOW_TIME, CMD_MODE};
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt <= '1;
        end else if (alarm_message_req) begin
            gap_cnt <= 32'h0;
        end else if (gap_cnt != '1) begin
            gap_cnt <= gap_cnt + 32'h1;
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_age <= '1;
        end else if (wr_stb && cmd_code == CMD_MODE) begin
            mode_age <= 32'h1;
        end else if (mode_age != '1) begin
            mode_age <= mode_age + 32'h1;
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_rd_ans; rd_stb |=> rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_lone; rd_valid |-> $past(rd_stb); endproperty
    a_rd_lone: assert property (p_rd_lone) else $error("valid without read");
    property p_unmap; (rd_stb || wr_stb) && !known |=> cmd_unmapped; endproperty
    a_unmap: assert property (p_unmap) else $error("unknown code not flagged");
    property p_mode_ro;
        rd_stb && cmd_code == CMD_MODE |=> {rd_data[12:8], rd_data[6:0]} == 12'h000;
    endproperty
    a_mode_ro: assert property (p_mode_ro) else $error("forced mode bits not zero");
    property p_wr_rd;
        wr_stb && known && cmd_code != CMD_MODE ##1 rd_stb && !wr_stb && $stable(cmd_code)
            |=> rd_data == $past(wr_data, 2);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("threshold readback differs");
    property p_hold;
        alarm_message_req && !alarm_message_done |=> alarm_message_req
            && $stable(alarm_message_status);
    endproperty
    a_hold: assert property (p_hold) else $error("alarm message dropped");
    property p_quiet;
        !alarm_bcast_en && !alarm_message_req ##1 !alarm_bcast_en |-> !alarm_message_req;
    endproperty
    a_quiet: assert property (p_quiet) else $error("alarm sent while disabled");
    property p_space; $rose(alarm_message_req) |-> gap_cnt >= GAP; endproperty
    a_space: assert property (p_space) else $error("alarms too close");
    property p_rearm; mode_age == REARM |-> alarm_bcast_en; endproperty
    a_rearm: assert property (p_rearm) else $error("alarm not re-enabled");
    property p_learn;
        learn_cycle_done && !charge_cycle_done |-> ##[1:2] !relearn_request;
    endproperty
    a_learn: assert property (p_learn) else $error("relearn not cleared");
    c_alarm: cover property ($rose(alarm_message_req));
    c_rearm: cover property (mode_age == REARM);
    c_mode_rd: cover property (rd_stb && cmd_code == CMD_MODE);
endmodule // bam_mode_regs_props

// ==== bam_msg_model.sv ====
// Message engine model that acknowledges alarm messages
`timescale 1ns/1ps
module bam_msg_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Message handshake
    input wire logic req,
    input wire logic slow,
    output logic done
);
    // ==========
    // Answer after one or six cycles, only while a message is open
    logic [3:0] wait_cnt;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= 4'h0;
            done <= 1'h0;
        end else if (!req || done) begin
            wait_cnt <= 4'h0;
            done <= 1'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
            done <= wait_cnt == (slow ? 4'h5 : 4'h0);
        end
    end
endmodule // bam_msg_model

// ==== tb_top.sv ====
// Self-checking bench of the battery alarm and mode register bank
`timescale 1ns/1ps
module tb_top
    import bam_pkg::*;
;
    // ==========
    // Signals
    typedef struct packed {logic [7:0] c; logic [15:0] w; logic [15:0] r;} bam_row_s;
    logic mclk, rstn, wr_stb, rd_stb, cfg_load, slow, sleep_entry;
    logic charge_cycle_done, full_charge_capacity_update, learn_cycle_done;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data, cfg_low_cap_default, cfg_low_time_default;
    logic [15:0] remaining_charge_report, avg_runtime_estimate;
    logic [1:0] alarm_message_status;
    logic rd_valid, cmd_unmapped, alarm_message_req, alarm_message_done;
    logic capacity_units_power, charge_bcast_en, alarm_bcast_en, relearn_request;
    int errors = 0;
    int comparisons = 0;
    int n;
    bam_row_s rows [7] = '{'{CMD_LOW_CAP, 16'hffff, 16'hffff}, '{CMD_LOW_TIME, 16'hffff, 16'hffff},
        '{CMD_LOW_TIME, 16'h0000, 16'h0000}, '{CMD_LOW_CAP, 16'h0001, 16'h0001},
        '{CMD_MODE, 16'hffff, 16'he080}, '{CMD_MODE, 16'h1f7f, 16'h0080},
        '{8'h07, 16'habcd, 16'h0000}};
    bam_mode_regs #(.CYCLES_SEC(10), .REARM_S(60), .SPACING_S(10), .RELEARN_COUNT(20))
    bam_mode_regs_i (.mclk, .rstn, .cmd_code, .wr_stb, .wr_data, .rd_stb, .rd_data, .rd_valid,
        .cmd_unmapped, .cfg_load, .cfg_low_cap_default, .cfg_low_time_default,
        .remaining_charge_report, .avg_runtime_estimate, .charge_cycle_done,
        .full_charge_capacity_update, .learn_cycle_done, .sleep_entry, .alarm_message_req,
        .alarm_message_status, .alarm_message_done, .capacity_units_power, .charge_bcast_en,
        .alarm_bcast_en, .relearn_request);
    bam_msg_model bam_msg_model_i (.mclk, .rstn, .req(alarm_message_req), .slow,
        .done(alarm_message_done));
    // ==========
    // Tasks, all entered just after a clock edge
    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        chk16(what, {15'h0, e}, {15'h0, g});
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        cmd_code = c;
        wr_data = d;
        wr_stb = 1'h1;
        @(posedge mclk);
        #1;
        wr_stb = 1'h0;
    endtask
    // Each strobe is followed by one idle edge so back-to-back calls never re-raise it at once
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic odd;
        odd = !(c inside {CMD_LOW_CAP, CMD_LOW_TIME, CMD_MODE});
        cmd_code = c;
        rd_stb = 1'h1;
        @(posedge mclk);
        #1;
        rd_stb = 1'h0;
        chk1("rd_valid", 1'h1, rd_valid);
        chk16("rd_data", e, rd_data);
        chk1("cmd_unmapped", odd, cmd_unmapped);
        @(posedge mclk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(posedge mclk);
        #1;
        s = 1'h0;
        @(posedge mclk);
        #1;
    endtask
    task automatic wait_lvl(input logic v, input int lim, output int c);
        c = 0;
        while (alarm_message_req !== v && c < lim) begin
            @(posedge mclk);
            #1;
            c++;
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========
    // Clock, watchdog and tests
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("unexpected watchdog: expected done, seen hang");
        report_and_stop;
    end
    initial begin
        {rstn, wr_stb, rd_stb, cfg_load, slow, sleep_entry, cmd_code, wr_data} = '0;
        {charge_cycle_done, full_charge_capacity_update, learn_cycle_done} = 3'h0;
        {remaining_charge_report, avg_runtime_estimate} = '1;
        cfg_low_cap_default = 16'h0100;
        cfg_low_time_default = 16'h0050;
        repeat (20) @(posedge mclk);
        #1;
        rstn = 1'h1;
        rd(CMD_MODE, 16'h0080);
        pulse(cfg_load);
        rd(CMD_LOW_CAP, 16'h0100);
        rd(CMD_LOW_TIME, 16'h0050);
        foreach (rows[i]) begin
            wr(rows[i].c, rows[i].w);
            rd(rows[i].c, rows[i].r);
        end
        wr(CMD_MODE, 16'hc000);
        @(posedge mclk);
        #1;
        chk1("capacity_units_power", 1'h1, capacity_units_power);
        chk1("charge_bcast_en", 1'h0, charge_bcast_en);
        wr(CMD_MODE, 16'h0000);
        @(posedge mclk);
        #1;
        chk1("capacity_units_power", 1'h0, capacity_units_power);
        chk1("charge_bcast_en", 1'h1, charge_bcast_en);
        // Capacity alarm, slow answer, then paced repeat
        wr(CMD_LOW_CAP, 16'h0100);
        remaining_charge_report = 16'h00ff;
        slow = 1'h1;
        wait_lvl(1'h1, 20, n);
        chk16("status", 16'h0002, {14'h0, alarm_message_status});
        wait_lvl(1'h0, 30, n);
        chk1("alarm_message_req", 1'h0, alarm_message_req);
        wait_lvl(1'h1, 200, n);
        chk1("paced alarm", 1'h1, n >= 100 && alarm_message_req === 1'h1);
        wait_lvl(1'h0, 30, n);
        chk1("alarm_message_req", 1'h0, alarm_message_req);
        // Time alarm, prompt answer; the rows left this threshold at zero
        remaining_charge_report = 16'hffff;
        avg_runtime_estimate = 16'h004f;
        slow = 1'h0;
        wr(CMD_LOW_TIME, 16'h0050);
        wait_lvl(1'h1, 200, n);
        chk16("status", 16'h0001, {14'h0, alarm_message_status});
        wait_lvl(1'h0, 30, n);
        chk1("alarm_message_req", 1'h0, alarm_message_req);
        // Disabled alarms stay quiet while rewritten, then re-arm
        wr(CMD_MODE, 16'h2000);
        wait_lvl(1'h1, 400, n);
        chk1("alarm_message_req", 1'h0, alarm_message_req);
        chk1("alarm_bcast_en", 1'h0, alarm_bcast_en);
        wr(CMD_MODE, 16'h2000);
        wait_lvl(1'h1, 580, n);
        chk1("alarm_message_req", 1'h0, alarm_message_req);
        wait_lvl(1'h1, 40, n);
        chk1("alarm_message_req", 1'h1, alarm_message_req);
        // Lets the re-arm age reach its checked value before the next mode write
        repeat (10) @(posedge mclk);
        #1;
        chk1("alarm_bcast_en", 1'h1, alarm_bcast_en);
        // Relearn flag and sleep entry
        pulse(learn_cycle_done);
        @(posedge mclk);
        #1;
        chk1("relearn_request", 1'h0, relearn_request);
        wr(CMD_MODE, 16'h0080);
        rd(CMD_MODE, 16'h0000);
        wr(CMD_MODE, 16'he000);
        pulse(sleep_entry);
        rd(CMD_MODE, 16'h0000);
        repeat (19) pulse(charge_cycle_done);
        pulse(full_charge_capacity_update);
        repeat (19) pulse(charge_cycle_done);
        @(posedge mclk);
        #1;
        chk1("relearn_request", 1'h0, relearn_request);
        pulse(charge_cycle_done);
        @(posedge mclk);
        #1;
        chk1("relearn_request", 1'h1, relearn_request);
        // Mid-run reset raises the relearn request again
        pulse(learn_cycle_done);
        rstn = 1'h0;
        repeat (2) @(posedge mclk);
        #1;
        chk1("relearn_request", 1'h1, relearn_request);
        rstn = 1'h1;
        rd(CMD_MODE, 16'h0080);
        report_and_stop;
    end
endmodule // tb_top

bind bam_mode_regs bam_mode_regs_props #(.CYCLES_SEC(CYCLES_SEC), .REARM_S(REARM_S),
    .SPACING_S(SPACING_S)) bam_mode_regs_props_i (.mclk, .rstn, .cmd_code, .wr_stb, .wr_data,
    .rd_stb, .rd_data, .rd_valid, .cmd_unmapped, .alarm_message_req, .alarm_message_status,
    .alarm_message_done, .alarm_bcast_en, .relearn_request, .learn_cycle_done,
    .charge_cycle_done);
